// File: include/usb_funnel_cfg.svh
// offsets, field positions, reset values and timing figures for the funnel
// assumes a 125 MHz aclk and 32-bit AXI4-Lite register access
`ifndef USB_FUNNEL_CFG_SVH
`define USB_FUNNEL_CFG_SVH

// register byte addresses
`define OFS_STATUS_FLAGS 4'h0
`define OFS_STATUS_EN 4'h4
`define OFS_ERROR_FLAGS 4'h8
`define OFS_ERROR_EN 4'hC
// control register lives above the four flag/enable words
`define OFS_CONTROL 5'h10

// status flag group bit positions
`define ST_RESET_BIT 0
`define ST_ERROR_BIT 1
`define ST_ACTIVITY_BIT 2
`define ST_TRANSFER_BIT 3
`define ST_IDLE_BIT 4
`define ST_STALL_BIT 5
`define ST_SOF_BIT 6

// control register bit positions
`define CTL_SUSPEND_BIT 0
`define CTL_PLL_SRC_BIT 1
`define CTL_OPERATIONAL_BIT 2

// reset values
`define FLAGS_RESET 8'h00
`define CTRL_RESET 2'h0

// idle time before the idle flag is raised, in microseconds
`define IDLE_TIME_US 3000
`define CLK_MHZ 125
// more than the idle time, so one cycle past the exact count
`define IDLE_CYCLES ((`IDLE_TIME_US * `CLK_MHZ) + 1)

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: include/usb_funnel_pkg.sv
// types shared by the event funnel and its flag register slice
// assumes the cfg header supplies offsets and reset values
`default_nettype none

package usb_funnel_pkg;

    // one write strobe from software toward an eight-bit flag group
    typedef struct packed {
        logic set_en;
        logic clr_en;
        logic [7:0] data;
    } flag_write_s;

    // wake-up sequencing after suspend is cleared
    typedef enum logic [1:0] {
        WAKE_RUN = 2'b00,
        WAKE_SUSPENDED = 2'b01,
        WAKE_SYNC = 2'b10
    } wake_state_e;

endpackage

`default_nettype wire

// File: hw/flag_group_reg.sv
// eight sticky flag bits: hardware sets, software clears or sets
// assumes set and clear strobes are single-cycle and synchronous to aclk
`default_nettype none

module flag_group_reg #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // hardware events and software write
    input wire logic [WIDTH-1:0] hw_set,
    input wire logic [WIDTH-1:0] clr_block,
    input wire usb_funnel_pkg::flag_write_s sw,
    // flag state
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;
    logic [WIDTH-1:0] sw_set;
    logic [WIDTH-1:0] sw_clr;

    // software writes a one to set, a zero to clear; blocked bits hold
    assign sw_set = sw.set_en ? sw.data[WIDTH-1:0] : '0;
    assign sw_clr = sw.clr_en ? (~sw.data[WIDTH-1:0] & ~clr_block) : '0;
    // set beats clear; no hardware self-clear path exists
    assign flags_d = (flags_q & ~sw_clr) | hw_set | sw_set;

    // flag storage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule

`default_nettype wire

// File: hw/usb_event_flag_funnel.sv
// usb event funnel: status and error flags, enables, idle and wake logic
// assumes an engine giving one-cycle event pulses and an AXI4-Lite master
// Contract
// - clearing the activity flag is ignored while suspended and during sync
// - with pll clocking, module stays down after suspend until lock
// - one activity event when traffic resumes after idle
// - after clear, activity flag not set again until new idle
// - enables only gate propagation; flags always set for polling
// - enabled error flags are ORed into the error summary flag
// - error flags set in the very cycle the condition is seen
// - engine-set flags stay set until firmware clears them
// - any enabled active error flag sets the error summary flag
// - idle flag sets after more than 3 ms without own traffic
// - enabled status flags ORed into one usb interrupt request
// - firmware writes can set any flag bit directly
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`include "usb_funnel_cfg.svh"
`default_nettype none

module usb_event_flag_funnel #(
    parameter int SYNC_CYCLES = 4,
    parameter int IDLE_CYCLES = `IDLE_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial interface engine events as one-cycle pulses; traffic and pll lock as levels
    input wire logic [7:0] status_events,
    input wire logic [7:0] error_events,
    input wire logic bus_traffic,
    input wire logic pll_locked,
    // processor interrupt logic
    output logic usb_interrupt_request,
    output logic suspend_control,
    output logic module_operational
);

    logic aw_held_q;
    logic [4:0] awaddr_q;
    logic w_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] status_en_q;
    logic [7:0] error_en_q;
    logic [1:0] ctrl_q;
    logic [7:0] status_flags;
    logic [7:0] error_flags;
    logic [31:0] idle_cnt_q;
    logic armed_q;
    logic [15:0] sync_cnt_q;
    usb_funnel_pkg::wake_state_e wake_q;
    usb_funnel_pkg::wake_state_e wake_d;
    usb_funnel_pkg::flag_write_s st_wr;
    usb_funnel_pkg::flag_write_s er_wr;

    // is a byte address one of the mapped words
    function automatic logic mapped(input logic [4:0] a);
        mapped = (a == {1'b0, `OFS_STATUS_FLAGS}) ||
                 (a == {1'b0, `OFS_STATUS_EN}) ||
                 (a == {1'b0, `OFS_ERROR_FLAGS}) ||
                 (a == {1'b0, `OFS_ERROR_EN}) ||
                 (a == `OFS_CONTROL);
    endfunction

    // write happens once both address and data are held
    wire do_write = aw_held_q && w_held_q && !bvalid_q;
    wire wr_lane0 = do_write && wstrb_q[0];
    wire wr_st_flags = wr_lane0 && (awaddr_q == {1'b0, `OFS_STATUS_FLAGS});
    wire wr_st_en = wr_lane0 && (awaddr_q == {1'b0, `OFS_STATUS_EN});
    wire wr_er_flags = wr_lane0 && (awaddr_q == {1'b0, `OFS_ERROR_FLAGS});
    wire wr_er_en = wr_lane0 && (awaddr_q == {1'b0, `OFS_ERROR_EN});
    wire wr_ctrl = wr_lane0 && (awaddr_q == `OFS_CONTROL);

    // handshake outputs
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready = !w_held_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // axi address and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read data mux
    wire [31:0] rd_word =
        (s_axi_araddr == {1'b0, `OFS_STATUS_FLAGS}) ? {24'h0, status_flags} :
        (s_axi_araddr == {1'b0, `OFS_STATUS_EN}) ? {24'h0, status_en_q} :
        (s_axi_araddr == {1'b0, `OFS_ERROR_FLAGS}) ? {24'h0, error_flags} :
        (s_axi_araddr == {1'b0, `OFS_ERROR_EN}) ? {24'h0, error_en_q} :
        (s_axi_araddr == `OFS_CONTROL) ?
            {29'h0, module_operational, ctrl_q} : 32'h0;

    // read response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // enable and control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_en_q <= `FLAGS_RESET;
            error_en_q <= `FLAGS_RESET;
            ctrl_q <= `CTRL_RESET;
        end else begin
            if (wr_st_en) begin
                status_en_q <= wdata_q[7:0];
            end
            if (wr_er_en) begin
                error_en_q <= wdata_q[7:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= wdata_q[1:0];
            end
        end
    end

    assign suspend_control = ctrl_q[`CTL_SUSPEND_BIT];

    // wake sequencing: suspended, then a fixed sync delay
    always_comb begin
        wake_d = wake_q;
        case (wake_q)
            usb_funnel_pkg::WAKE_RUN: begin
                if (suspend_control) begin
                    wake_d = usb_funnel_pkg::WAKE_SUSPENDED;
                end
            end
            usb_funnel_pkg::WAKE_SUSPENDED: begin
                if (!suspend_control) begin
                    wake_d = usb_funnel_pkg::WAKE_SYNC;
                end
            end
            usb_funnel_pkg::WAKE_SYNC: begin
                if (suspend_control) begin
                    wake_d = usb_funnel_pkg::WAKE_SUSPENDED;
                end else if (sync_cnt_q >= 16'(SYNC_CYCLES - 1)) begin
                    wake_d = usb_funnel_pkg::WAKE_RUN;
                end
            end
            default: wake_d = usb_funnel_pkg::WAKE_RUN;
        endcase
    end

    // wake state and sync counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_q <= usb_funnel_pkg::WAKE_RUN;
            sync_cnt_q <= '0;
        end else begin
            wake_q <= wake_d;
            sync_cnt_q <= (wake_q == usb_funnel_pkg::WAKE_SYNC) ?
                sync_cnt_q + 16'h1 : 16'h0;
        end
    end

    // activity clear is blocked outside normal running, and already in
    // the first cycle of suspend before the wake state has caught up
    wire act_clr_block = suspend_control ||
        (wake_q != usb_funnel_pkg::WAKE_RUN);

    // pll-clocked module waits for lock after suspend
    assign module_operational = !suspend_control &&
        (!ctrl_q[`CTL_PLL_SRC_BIT] || pll_locked);

    // idle timer counts cycles without own traffic
    wire idle_hit = (idle_cnt_q == 32'(IDLE_CYCLES - 1)) && !bus_traffic;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_cnt_q <= '0;
            armed_q <= 1'b0;
        end else begin
            if (bus_traffic) begin
                idle_cnt_q <= '0;
            // stop one past the threshold so the hit fires once per idle
            end else if (idle_cnt_q != 32'(IDLE_CYCLES)) begin
                idle_cnt_q <= idle_cnt_q + 32'h1;
            end
            // one activity event per idle period
            if (idle_hit) begin
                armed_q <= 1'b1;
            end else if (bus_traffic) begin
                armed_q <= 1'b0;
            end
        end
    end

    // single-cycle idle event at the threshold
    wire idle_event = idle_hit;
    wire act_event = armed_q && bus_traffic;

    // hardware sets for each group, error bits set the cycle seen
    wire [7:0] st_hw = status_events |
        (8'(act_event) << `ST_ACTIVITY_BIT) |
        (8'(idle_event) << `ST_IDLE_BIT) |
        (8'(|(error_flags & error_en_q)) << `ST_ERROR_BIT);
    wire [7:0] st_block = 8'(act_clr_block) << `ST_ACTIVITY_BIT;

    assign st_wr = '{set_en: wr_st_flags, clr_en: wr_st_flags,
                     data: wdata_q[7:0]};
    assign er_wr = '{set_en: wr_er_flags, clr_en: wr_er_flags,
                     data: wdata_q[7:0]};

    // status flag group
    flag_group_reg #(.WIDTH(8)) u_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .hw_set(st_hw),
        .clr_block(st_block),
        .sw(st_wr),
        .flags(status_flags)
    );

    // error flag group
    flag_group_reg #(.WIDTH(8)) u_error (
        .aclk(aclk),
        .aresetn(aresetn),
        .hw_set(error_events),
        .clr_block(8'h00),
        .sw(er_wr),
        .flags(error_flags)
    );

    // funnel of enabled status flags to the processor
    assign usb_interrupt_request = |(status_flags & status_en_q);

endmodule

`default_nettype wire

// File: test/usb_funnel_checker.sv
// checker: bus handshakes and funnel outputs of the event funnel
// assumes it is bound into usb_event_flag_funnel
`default_nettype none

module usb_funnel_checker #(
    parameter int SYNC_CYCLES = 4,
    parameter int IDLE_CYCLES = 20
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // funnel outputs
    input wire logic usb_interrupt_request,
    input wire logic suspend_control,
    input wire logic module_operational
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // address and data of a write taken together
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // answers arrive within the stated cycles
    wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response late");
    // responses stand until taken
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while read pending");
    rd_upper_a: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp != 2'h1)
        else $error("read word malformed");
    // request only falls through a firmware write
    irq_sticky_a: assert property (
        $fell(usb_interrupt_request) |-> $rose(s_axi_bvalid))
        else $error("interrupt request self-cleared");
    susp_write_a: assert property (
        $changed(suspend_control) |-> $rose(s_axi_bvalid))
        else $error("suspend changed without write");
    op_gate_a: assert property (
        suspend_control |-> !module_operational)
        else $error("operational while suspended");
endmodule

bind usb_event_flag_funnel usb_funnel_checker #(
    .SYNC_CYCLES(SYNC_CYCLES),
    .IDLE_CYCLES(IDLE_CYCLES)
) chk_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .usb_interrupt_request(usb_interrupt_request),
    .suspend_control(suspend_control),
    .module_operational(module_operational)
);

`default_nettype wire

// File: test/usb_engine_model.sv
// engine model: bench requests become one-cycle events and levels
// assumes requests change just after the rising edge of aclk
`default_nettype none

module usb_engine_model (
    // clock
    input wire logic aclk,
    // requests from the bench
    input wire logic [7:0] st_req,
    input wire logic [7:0] er_req,
    input wire logic traffic_req,
    input wire logic lock_req,
    // toward the funnel
    output logic [7:0] status_events,
    output logic [7:0] error_events,
    output logic bus_traffic,
    output logic pll_locked
);
    timeunit 1ns;
    timeprecision 1ps;
    // no engine events at time zero, bus traffic present
    initial begin
        status_events = 8'h00;
        error_events = 8'h00;
        bus_traffic = 1'b1;
        pll_locked = 1'b0;
    end
    // events follow one-cycle requests, levels follow their request
    always @(posedge aclk) begin
        status_events <= st_req;
        error_events <= er_req;
        bus_traffic <= traffic_req;
        pll_locked <= lock_req;
    end
endmodule

`default_nettype wire

// File: test/usb_event_flag_funnel_bench.sv
// bench: register-level tests of the event funnel
// assumes the engine model and the bound checker
`include "usb_funnel_cfg.svh"
`default_nettype none

module usb_event_flag_funnel_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE = 20;
    localparam int SYNC = 12;
    localparam logic [4:0] ADR_ST = {1'b0, `OFS_STATUS_FLAGS};
    localparam logic [4:0] ADR_SE = {1'b0, `OFS_STATUS_EN};
    localparam logic [4:0] ADR_ER = {1'b0, `OFS_ERROR_FLAGS};
    localparam logic [4:0] ADR_EE = {1'b0, `OFS_ERROR_EN};
    localparam logic [4:0] ADR_CT = `OFS_CONTROL;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r, b;
    logic [7:0] st_req = 8'h00, er_req = 8'h00;
    logic traffic_req = 1'b1, lock_req = 1'b0;
    logic [7:0] st_ev, er_ev;
    logic traffic, locked, irq, susp, oper;
    logic [31:0] d;
    int error_cnt = 0, total_checks = 0, n;

    // 125 MHz clock
    always #4 aclk = ~aclk;

    usb_engine_model eng (.aclk(aclk), .st_req(st_req), .er_req(er_req),
        .traffic_req(traffic_req), .lock_req(lock_req),
        .status_events(st_ev), .error_events(er_ev),
        .bus_traffic(traffic), .pll_locked(locked));

    usb_event_flag_funnel #(.SYNC_CYCLES(SYNC), .IDLE_CYCLES(IDLE)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .status_events(st_ev), .error_events(er_ev),
        .bus_traffic(traffic), .pll_locked(locked),
        .usb_interrupt_request(irq), .suspend_control(susp),
        .module_operational(oper));

    // compare and count
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // one write, address and data offered together
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        logic pa, pw;
        int k;
        pa = 1'b1;
        pw = 1'b1;
        k = 0;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while ((pa || pw) && k < 50) begin
            @(posedge aclk);
            k++;
            if (pa && awready === 1'b1) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready === 1'b1) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            k++;
        end while (bvalid !== 1'b1 && k < 50);
        b = bresp;
        bready <= 1'b0;
        if (k >= 50) cmp(32'h0, 32'h1);
        @(posedge aclk);
    endtask

    // one read
    task automatic rd(input logic [4:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
        end while (arready !== 1'b1 && k < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            k++;
        end while (rvalid !== 1'b1 && k < 50);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (k >= 50) cmp(32'h0, 32'h1);
        @(posedge aclk);
    endtask

    task automatic chk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        cmp(v, e);
    endtask

    // one-cycle engine events
    task automatic ev(input logic [7:0] s, input logic [7:0] e);
        st_req <= s;
        er_req <= e;
        @(posedge aclk);
        st_req <= 8'h00;
        er_req <= 8'h00;
        repeat (2) @(posedge aclk);
    endtask

    // traffic stops long enough for idle, then resumes
    task automatic go_idle();
        traffic_req <= 1'b0;
        repeat (IDLE + 4) @(posedge aclk);
        traffic_req <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (6000) @(posedge aclk);
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, unmapped word refused
        for (int i = 0; i < 4; i++) chk(5'(i * 4), 32'h0);
        chk(ADR_CT, 32'h04);
        rd(5'h14, d, r);
        cmp({30'h0, r}, {30'h0, `RESP_SLVERR});
        // unmapped write answers an error and changes nothing
        wr(5'h14, 8'hFF);
        cmp({30'h0, b}, {30'h0, `RESP_SLVERR});
        // flags set with enables off, no request
        ev(8'h08, 8'h04);
        chk(ADR_ST, 32'h08);
        chk(ADR_ER, 32'h04);
        cmp({31'h0, irq}, 32'h0);
        wr(ADR_SE, 8'h0A);
        cmp({30'h0, b}, {30'h0, `RESP_OKAY});
        cmp({31'h0, irq}, 32'h1);
        wr(ADR_EE, 8'h04);
        repeat (30) @(posedge aclk);
        chk(ADR_ST, 32'h0A);
        // direct set; summary held by hardware over the clear
        wr(ADR_ST, 8'h40);
        chk(ADR_ST, 32'h42);
        wr(ADR_EE, 8'h00);
        wr(ADR_ER, 8'h00);
        wr(ADR_ST, 8'h00);
        chk(ADR_ST, 32'h0);
        cmp({31'h0, irq}, 32'h0);
        // idle, one activity event, no repeat under traffic
        traffic_req <= 1'b0;
        repeat (IDLE - 8) @(posedge aclk);
        chk(ADR_ST, 32'h0);
        repeat (12) @(posedge aclk);
        chk(ADR_ST, 32'h10);
        // idle flag cleared while still idle must stay clear
        wr(ADR_ST, 8'h00);
        chk(ADR_ST, 32'h0);
        traffic_req <= 1'b1;
        repeat (3) @(posedge aclk);
        chk(ADR_ST, 32'h04);
        wr(ADR_ST, 8'h00);
        repeat (20) @(posedge aclk);
        chk(ADR_ST, 32'h0);
        // activity clear blocked in suspend and in sync
        wr(ADR_CT, 8'h01);
        chk(ADR_CT, 32'h01);
        cmp({31'h0, susp}, 32'h1);
        cmp({31'h0, oper}, 32'h0);
        go_idle();
        wr(ADR_ST, 8'h00);
        chk(ADR_ST, 32'h04);
        wr(ADR_CT, 8'h00);
        wr(ADR_ST, 8'h00);
        chk(ADR_ST, 32'h04);
        n = 0;
        d = 32'h4;
        while (d[2] === 1'b1 && n < 20) begin
            wr(ADR_ST, 8'h00);
            rd(ADR_ST, d, r);
            n++;
        end
        cmp(d, 32'h0);
        // pll clock source waits for lock
        wr(ADR_CT, 8'h02);
        chk(ADR_CT, 32'h02);
        lock_req <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(ADR_CT, 32'h06);
        cmp({31'h0, oper}, 32'h1);
        cmp({31'h0, susp}, 32'h0);
        close_out();
    end
endmodule

`default_nettype wire
